/* File: verilog/lcsf_pkg.sv */
package lcsf_pkg;

  // ****************************************************************
  // Sizes and field positions
  // ****************************************************************
  localparam int NPORT = 8;
  localparam int MAXCH = 8;
  localparam int CH_BITS = 32;
  localparam logic [4:0] CH_LAST_BIT = 5'h1f;
  localparam logic [8:0] PP_DOWN_BITS = 9'h020;
  localparam logic [8:0] PP_LAST_BIT = 9'h03f;
  localparam logic [8:0] PP_DOWN_LAST = 9'h01f;
  localparam int MON_HI = 15;
  localparam int MON_LO = 8;
  localparam int CTRL_MR = 1;
  localparam int CTRL_MX = 0;
  localparam logic [4:0] D_FIRST = 5'h18;
  localparam logic [4:0] D_LAST = 5'h19;
  localparam logic MON_ACT = 1'b1;
  localparam logic [3:0] CH_SINGLE = 4'h1;
  localparam logic [3:0] CH_MULTI = 4'h8;
  localparam logic [3:0] CH_TERM = 4'h3;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    FMT_SINGLE,
    FMT_MUX,
    FMT_ENH_LC,
    FMT_ENH_TE,
    FMT_ENH_NT,
    FMT_PINGPONG
  } lcsf_fmt_t;

  typedef struct packed {
    lcsf_fmt_t fmt;
    logic ci6;
    logic [2:0] mon_port;
    logic [2:0] mon_chan;
  } lcsf_cfg_t;

  typedef struct packed {
    logic [2:0] port;
    logic [2:0] chan;
    logic [CH_BITS-1:0] data;
  } lcsf_slot_wr_t;

  typedef struct packed {
    logic [2:0] chan;
    logic [NPORT-1:0][CH_BITS-1:0] data;
  } lcsf_rx_word_t;

  function automatic logic [3:0] lcsf_chan_count(lcsf_fmt_t fmt);
    case (fmt)
      FMT_MUX, FMT_ENH_LC: lcsf_chan_count = CH_MULTI;
      FMT_ENH_TE: lcsf_chan_count = CH_TERM;
      default: lcsf_chan_count = CH_SINGLE;
    endcase
  endfunction

endpackage

/* File: verilog/lcsf_frame.sv */
// Notes on behaviour
// - Single format: four byte slots per frame
// - Slots carry B1, B2, monitor, D/CI/T/E
// - Command/indication resent in every frame
// - Single format: one monitor byte, E marks it
// - Single format: 256 kbit/s, double-rate clock
// - Multiplexed: eight channels, 2048 kbit/s
// - Multiplexed: shifted bit timing and sync
// - Enhanced: half-rate bits, single-format timing
// - Enhanced line card: handshaken monitor bytes
// - Enhanced: four or six CI bits
// - Terminal variant: three channels, 768 kbit/s
// - Terminal: channel three CI carries arbitration
// - Enhanced single channel at 256 kbit/s
// - Ping-pong: device drives direction, eight ports
// - Ping-pong: four bytes down, four up
// - Ping-pong bytes: B1, B2, feature, signalling
// - Downstream slot values repeat until rewritten
module lcsf_frame (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic i_dcl,
  input wire logic i_frame_sync,
  input wire logic [lcsf_pkg::NPORT-1:0] i_port_rx,
  input wire logic i_cfg_wr,
  input wire lcsf_pkg::lcsf_cfg_t i_cfg,
  input wire logic i_slot_wr,
  input wire lcsf_pkg::lcsf_slot_wr_t i_slot,
  input wire logic i_mon_valid,
  input wire logic [7:0] i_mon_byte,
  input wire logic i_rx_ready,
  output logic o_mon_ready,
  output logic [lcsf_pkg::NPORT-1:0] o_port_tx,
  output logic [lcsf_pkg::NPORT-1:0] o_port_oe_n,
  output logic o_frame_sync,
  output logic o_rx_valid,
  output lcsf_pkg::lcsf_rx_word_t o_rx_word,
  output logic o_rx_overflow
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic {MON_IDLE, MON_SEND} lcsf_mon_t;

  typedef struct packed {
    logic [2:0] dcl_s;
    logic [2:0] fs_s;
    logic [2:0][lcsf_pkg::NPORT-1:0] rx_s;
    logic dcl_f;
    logic fs_f;
    logic [lcsf_pkg::NPORT-1:0] rx_f;
    lcsf_pkg::lcsf_cfg_t cfg;
    logic [lcsf_pkg::NPORT*lcsf_pkg::MAXCH-1:0][lcsf_pkg::CH_BITS-1:0] mem;
    logic active;
    logic phase;
    logic have;
    logic [8:0] bcnt;
    logic [lcsf_pkg::NPORT-1:0][lcsf_pkg::CH_BITS-1:0] sh;
    logic [lcsf_pkg::NPORT-1:0] tx;
    logic [lcsf_pkg::NPORT-1:0] oe_n;
    logic fs_out;
    lcsf_mon_t mon;
    logic [7:0] mon_byte;
    logic mon_rdy;
    logic mr_pend;
    lcsf_pkg::lcsf_rx_word_t b0;
    lcsf_pkg::lcsf_rx_word_t b1;
    logic v0;
    logic v1;
    logic ovf;
  } lcsf_state_t;

  lcsf_state_t st_r;
  lcsf_state_t st_nxt;
  logic rise, fall, fs_rise, launch, sample, fstart, pp, mux, hs, sel;
  logic [8:0] lim;
  logic [2:0] ch;
  logic [4:0] k;
  logic [lcsf_pkg::CH_BITS-1:0] word;
  logic [lcsf_pkg::CH_BITS-1:0] mon_rx;
  lcsf_pkg::lcsf_rx_word_t pw;

  // Builds the outgoing channel word: stored slot values, with the monitor
  // byte and its handshake bits laid over it on the selected channel.
  function automatic logic [lcsf_pkg::CH_BITS-1:0] compose(
    input logic [lcsf_pkg::CH_BITS-1:0] m, input logic sel_ch, input logic send,
    input logic [7:0] mb, input logic handshake, input logic mr, input logic ping);
    compose = m;
    if (sel_ch && send) begin
      compose[lcsf_pkg::MON_HI:lcsf_pkg::MON_LO] = mb;
    end
    if (sel_ch && !ping) begin
      compose[lcsf_pkg::CTRL_MX] = send ? lcsf_pkg::MON_ACT : ~lcsf_pkg::MON_ACT;
    end
    if (sel_ch && handshake) begin
      compose[lcsf_pkg::CTRL_MR] = mr ? lcsf_pkg::MON_ACT : ~lcsf_pkg::MON_ACT;
    end
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    rise = 1'b0;
    fall = 1'b0;
    fs_rise = 1'b0;
    launch = 1'b0;
    sample = 1'b0;
    fstart = 1'b0;
    word = '0;
    mon_rx = '0;
    pw = '0;
    sel = 1'b0;
    // A pin level counts only once the second and third stages agree.
    st_nxt.dcl_s = {st_r.dcl_s[1:0], i_dcl};
    st_nxt.fs_s = {st_r.fs_s[1:0], i_frame_sync};
    st_nxt.rx_s = {st_r.rx_s[1:0], i_port_rx};
    if (st_r.dcl_s[1] == st_r.dcl_s[2]) begin
      st_nxt.dcl_f = st_r.dcl_s[2];
    end
    if (st_r.fs_s[1] == st_r.fs_s[2]) begin
      st_nxt.fs_f = st_r.fs_s[2];
    end
    for (int p = 0; p < lcsf_pkg::NPORT; p++) begin
      if (st_r.rx_s[1][p] == st_r.rx_s[2][p]) begin
        st_nxt.rx_f[p] = st_r.rx_s[2][p];
      end
    end
    rise = st_nxt.dcl_f & ~st_r.dcl_f;
    fall = ~st_nxt.dcl_f & st_r.dcl_f;
    fs_rise = st_nxt.fs_f & ~st_r.fs_f;
    pp = (st_r.cfg.fmt == lcsf_pkg::FMT_PINGPONG);
    mux = (st_r.cfg.fmt == lcsf_pkg::FMT_MUX);
    hs = (st_r.cfg.fmt inside {lcsf_pkg::FMT_ENH_LC, lcsf_pkg::FMT_ENH_TE,
                               lcsf_pkg::FMT_ENH_NT});
    // Channel count per frame sets the frame length.
    lim = {lcsf_pkg::lcsf_chan_count(st_r.cfg.fmt), 5'h00};
    ch = pp ? 3'h0 : st_r.bcnt[7:5];
    k = st_r.bcnt[4:0];

    if (i_cfg_wr) begin
      // The format is held until the next configuration write.
      st_nxt.cfg = i_cfg;
      st_nxt.active = 1'b0;
      st_nxt.bcnt = '0;
      st_nxt.phase = 1'b0;
      st_nxt.have = 1'b0;
      st_nxt.oe_n = '1;
      st_nxt.ovf = 1'b0;
      // The direction output rests low outside ping-pong.
      st_nxt.fs_out = 1'b0;
    end else if (!pp && fs_rise) begin
      st_nxt.active = 1'b1;
      st_nxt.bcnt = '0;
      st_nxt.phase = 1'b0;
      st_nxt.have = 1'b0;
      fstart = 1'b1;
    end else if (pp) begin
      // One bit per clock cycle; the device owns the direction line.
      launch = rise;
      sample = fall & st_r.have;
      fstart = rise && (st_r.bcnt == '0);
    end else begin
      // Double-rate clock: a bit lasts two cycles.
      if (rise) begin
        st_nxt.phase = ~st_r.phase;
      end
      // The multiplexed format launches on the falling edge, half a
      // clock later than the other formats.
      launch = st_r.active & ~st_r.have &
               (mux ? (fall & st_r.phase) : (rise & ~st_r.phase));
      sample = st_r.active & st_r.have & ~st_r.phase & (mux ? rise : fall);
    end

    if (launch) begin
      st_nxt.have = 1'b1;
      if (pp) begin
        st_nxt.fs_out = (st_r.bcnt < lcsf_pkg::PP_DOWN_BITS);
      end
      for (int p = 0; p < lcsf_pkg::NPORT; p++) begin
        sel = (3'(p) == st_r.cfg.mon_port) && (pp || ch == st_r.cfg.mon_chan);
        // Stored values go out in every frame until rewritten.
        word = compose(st_r.mem[{3'(p), ch}], sel, st_r.mon == MON_SEND,
                       st_r.mon_byte, hs, st_r.mr_pend, pp);
        st_nxt.tx[p] = word[lcsf_pkg::CH_LAST_BIT - k];
        if (pp) begin
          st_nxt.oe_n[p] = (st_r.bcnt >= lcsf_pkg::PP_DOWN_BITS);
        end else begin
          // With four CI bits the D bits are left undriven.
          st_nxt.oe_n[p] = !st_r.cfg.ci6 && (k inside {lcsf_pkg::D_FIRST, lcsf_pkg::D_LAST});
        end
      end
    end

    if (sample) begin
      st_nxt.have = 1'b0;
      for (int p = 0; p < lcsf_pkg::NPORT; p++) begin
        if (!pp || st_r.bcnt >= lcsf_pkg::PP_DOWN_BITS) begin
          st_nxt.sh[p] = {st_r.sh[p][lcsf_pkg::CH_BITS-2:0], st_nxt.rx_f[p]};
        end
      end
      mon_rx = st_nxt.sh[st_r.cfg.mon_port];
      if (k == lcsf_pkg::CH_LAST_BIT && (!pp || st_r.bcnt == lcsf_pkg::PP_LAST_BIT)) begin
        pw.chan = ch;
        pw.data = st_nxt.sh;
      end
      if (!pp && k == lcsf_pkg::CH_LAST_BIT && ch == st_r.cfg.mon_chan) begin
        // Acknowledge a received monitor byte in the next frame.
        st_nxt.mr_pend = hs && (mon_rx[lcsf_pkg::CTRL_MX] == lcsf_pkg::MON_ACT);
        if (st_r.mon == MON_SEND &&
            (!hs || mon_rx[lcsf_pkg::CTRL_MR] == lcsf_pkg::MON_ACT)) begin
          st_nxt.mon = MON_IDLE;
          st_nxt.mon_rdy = 1'b1;
        end
      end
      if (pp && st_r.bcnt == lcsf_pkg::PP_DOWN_LAST && st_r.mon == MON_SEND) begin
        st_nxt.mon = MON_IDLE;
        st_nxt.mon_rdy = 1'b1;
      end
      if (pp) begin
        st_nxt.bcnt = (st_r.bcnt == lcsf_pkg::PP_LAST_BIT) ? '0 : st_r.bcnt + 9'h001;
      end else begin
        st_nxt.bcnt = st_r.bcnt + 9'h001;
        if (st_r.bcnt + 9'h001 == lim) begin
          st_nxt.active = 1'b0;
          st_nxt.oe_n = '1;
        end
      end
    end

    // A new monitor byte is taken only at a frame start, so a channel never
    // carries half of one byte and half of the next.
    if (fstart && st_r.mon == MON_IDLE && st_r.mon_rdy && i_mon_valid) begin
      st_nxt.mon = MON_SEND;
      st_nxt.mon_byte = i_mon_byte;
      st_nxt.mon_rdy = 1'b0;
    end

    if (i_slot_wr) begin
      st_nxt.mem[{i_slot.port, i_slot.chan}] = i_slot.data;
    end

    // Two-entry buffer: b0 is the output stage, b1 holds a word while the
    // receiver stalls. A third word while both are full is counted lost.
    if (st_r.v0 && i_rx_ready) begin
      st_nxt.v0 = st_r.v1;
      st_nxt.b0 = st_r.b1;
      st_nxt.v1 = 1'b0;
    end
    if (sample && k == lcsf_pkg::CH_LAST_BIT &&
        (!pp || st_r.bcnt == lcsf_pkg::PP_LAST_BIT)) begin
      if (!st_nxt.v0) begin
        st_nxt.b0 = pw;
        st_nxt.v0 = 1'b1;
      end else if (!st_nxt.v1) begin
        st_nxt.b1 = pw;
        st_nxt.v1 = 1'b1;
      end else begin
        st_nxt.ovf = 1'b1;
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
      st_r.oe_n <= '1;
      st_r.mon_rdy <= 1'b1;
      st_r.mon <= MON_IDLE;
      st_r.cfg.fmt <= lcsf_pkg::FMT_SINGLE;
    end else if (i_clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign o_port_tx = st_r.tx;
  assign o_port_oe_n = st_r.oe_n;
  assign o_frame_sync = st_r.fs_out;
  assign o_rx_valid = st_r.v0;
  assign o_rx_word = st_r.b0;
  assign o_rx_overflow = st_r.ovf;
  assign o_mon_ready = st_r.mon_rdy;

endmodule // lcsf_frame

/* File: testbench/lcsf_frame_asserts.sv */
// ********************
// Port checks
// ********************
module lcsf_frame_asserts (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic i_cfg_wr,
  input wire lcsf_pkg::lcsf_cfg_t i_cfg,
  input wire logic i_mon_valid,
  input wire logic i_rx_ready,
  input wire logic o_mon_ready,
  input wire logic [lcsf_pkg::NPORT-1:0] o_port_oe_n,
  input wire logic o_frame_sync,
  input wire logic o_rx_valid,
  input wire lcsf_pkg::lcsf_rx_word_t o_rx_word,
  input wire logic o_rx_overflow
);
  timeunit 1ns;
  timeprecision 1ns;
  logic cw;
  logic pp_r;
  assign cw = i_cfg_wr & i_clk_en;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pp_r <= 1'b0;
    end else if (cw) begin
      pp_r <= (i_cfg.fmt == lcsf_pkg::FMT_PINGPONG);
    end
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  a_reset_idle: assert property ($rose(i_rst_n) |-> &o_port_oe_n && !o_rx_valid && o_mon_ready)
    else $error("outputs not idle after reset");
  a_cfg_abort: assert property (cw |=> &o_port_oe_n && !o_rx_overflow)
    else $error("config write did not abort the frame");
  a_ovf_sticky: assert property (o_rx_overflow && !cw |=> o_rx_overflow)
    else $error("overflow flag dropped");
  a_ovf_cause: assert property ($rose(o_rx_overflow) |-> $past(o_rx_valid))
    else $error("overflow with empty buffer");
  a_rx_hold: assert property (o_rx_valid && !i_rx_ready && !cw |=> o_rx_valid && $stable(o_rx_word))
    else $error("stalled word changed");
  a_dir_idle: assert property (!pp_r && !$past(cw) |-> !o_frame_sync)
    else $error("direction output outside ping-pong");
  a_pp_drive: assert property (pp_r && !$past(cw) |->
    o_port_oe_n == {lcsf_pkg::NPORT{!o_frame_sync}})
    else $error("ping-pong enable does not follow direction");
  a_mon_offer: assert property ($fell(o_mon_ready) |-> $past(i_mon_valid))
    else $error("monitor ready dropped without offer");
  a_en_freeze: assert property (!i_clk_en |=> $stable(o_port_oe_n) && $stable(o_rx_valid))
    else $error("state moved while disabled");
  c_pp_dir: cover property (pp_r && $fell(o_frame_sync));
  c_ovf: cover property ($rose(o_rx_overflow));
  c_mon: cover property ($fell(o_mon_ready));
endmodule // lcsf_frame_asserts

/* File: testbench/lcsf_line_model.sv */
// ********************
// Line device model
// ********************
module lcsf_line_model (
  input wire logic [7:0] i_tx,
  input wire logic [7:0] i_oe_n,
  input wire logic i_dir,
  output logic o_dcl,
  output logic o_sync,
  output logic [7:0] o_rx
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] up [8];
  logic [31:0] cap [8];
  logic [31:0] oec;
  logic [7:0] drv = 8'h00;
  logic pp = 1'b0;
  int dirc;
  // Ping-pong shares one wire, so the device enable decides who owns it.
  assign o_rx = pp ? ((i_oe_n & drv) | (~i_oe_n & i_tx)) : drv;
  initial begin
    o_dcl = 1'b0;
    o_sync = 1'b0;
  end
  task automatic grab();
    for (int p = 0; p < 8; p++) begin
      cap[p] = {cap[p][30:0], i_tx[p]};
    end
    oec = {oec[30:0], i_oe_n[0]};
  endtask
  // The clock stands still between frames; idle lines toggle so stale data is never seen.
  task automatic frame(input int n);
    int b;
    dirc = 0;
    o_sync = !pp;
    #400;
    for (int k = 0; k < n; k++) begin
      if (pp && k > 0 && i_dir) begin
        grab();
        dirc++;
      end
      b = pp ? k - 32 : k / 2;
      for (int p = 0; p < 8; p++) begin
        drv[p] = (b >= 0 && b < 32) ? up[p][31 - b] : ~drv[p];
      end
      o_dcl = 1'b1;
      #400;
      o_dcl = 1'b0;
      o_sync = 1'b0;
      if (!pp && k % 2 == 1) grab();
      #400;
    end
    drv = ~drv;
  endtask
endmodule // lcsf_line_model

/* File: testbench/lcsf_frame_tb_top.sv */
// ********************
// Bench
// ********************
module lcsf_frame_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LIMIT = 20000;
  logic clk, rst_n, clk_en, cfg_wr, slot_wr, mon_valid, rx_ready, double_rate_data_clock, fs, dir;
  logic rx_valid, ovf, mon_ready;
  logic [7:0] mon_byte, tx, oe_n, rx;
  lcsf_pkg::lcsf_cfg_t cfg;
  lcsf_pkg::lcsf_slot_wr_t slot;
  lcsf_pkg::lcsf_rx_word_t rx_word;
  logic [31:0] w [8];
  int fails = 0, n_checks = 0, cyc = 0, seed, i, p;
  lcsf_frame lcsf_frame_inst (.i_ref_clk(clk), .i_rst_n(rst_n), .i_clk_en(clk_en),
    .i_dcl(double_rate_data_clock), .i_frame_sync(fs), .i_port_rx(rx), .i_cfg_wr(cfg_wr), .i_cfg(cfg),
    .i_slot_wr(slot_wr), .i_slot(slot), .i_mon_valid(mon_valid), .i_mon_byte(mon_byte),
    .i_rx_ready(rx_ready), .o_mon_ready(mon_ready), .o_port_tx(tx), .o_port_oe_n(oe_n),
    .o_frame_sync(dir), .o_rx_valid(rx_valid), .o_rx_word(rx_word), .o_rx_overflow(ovf));
  lcsf_line_model lcsf_line_model_inst (.i_tx(tx), .i_oe_n(oe_n), .i_dir(dir), .o_dcl(double_rate_data_clock),
    .o_sync(fs), .o_rx(rx));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    if (fails == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fails++;
      finish_test();
    end
  end
  // With four-bit CI the D bits belong to the line, so only their enable is compared.
  function automatic logic [31:0] dmask(input logic c6);
    return c6 ? 32'hFFFF_FFFF : 32'hFFFF_FF3F;
  endfunction
  task automatic wr_cfg(input lcsf_pkg::lcsf_fmt_t f, input logic c6);
    @(negedge clk);
    cfg = '0;
    cfg.fmt = f;
    cfg.ci6 = c6;
    cfg_wr = 1'b1;
    lcsf_line_model_inst.pp = (f == lcsf_pkg::FMT_PINGPONG);
    @(negedge clk);
    cfg_wr = 1'b0;
  endtask
  task automatic fill(input logic [31:0] last);
    for (p = 0; p < 8; p++) begin
      w[p] = (p == 7) ? last : $random(seed);
      // The monitor channel's E bit is owned by the monitor logic and rests low.
      if (p == 0) begin
        w[p][0] = 1'b0;
      end
      lcsf_line_model_inst.up[p] = $random(seed);
      @(negedge clk);
      slot.port = p[2:0];
      slot.chan = 3'h0;
      slot.data = w[p];
      slot_wr = 1'b1;
    end
    @(negedge clk);
    slot_wr = 1'b0;
  endtask
  task automatic run(input int n);
    lcsf_line_model_inst.frame(n);
    repeat (8) @(negedge clk);
  endtask
  task automatic chk_frame(input logic c6);
    for (p = 0; p < 8; p++) begin
      chk(lcsf_line_model_inst.cap[p] & dmask(c6), w[p] & dmask(c6));
    end
    chk(lcsf_line_model_inst.oec, ~dmask(c6));
  endtask
  task automatic pop(input logic [31:0] up0);
    chk(32'(rx_valid), 32'h1);
    chk(32'(rx_word.chan), 32'h0);
    chk(rx_word.data[0], up0);
    for (p = 1; p < 8; p++) begin
      chk(rx_word.data[p], lcsf_line_model_inst.up[p]);
    end
    @(negedge clk);
    rx_ready = 1'b1;
    @(negedge clk);
    rx_ready = 1'b0;
  endtask
  initial begin
    {rst_n, cfg_wr, slot_wr, mon_valid, rx_ready} = '0;
    clk_en = 1'b1;
    cfg = '0;
    slot = '0;
    mon_byte = 8'h00;
    seed = 53;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    chk({tx, oe_n, 12'h000, rx_valid, ovf, mon_ready, dir}, 32'h00FF_0002);
    for (i = 0; i < 2; i++) begin
      wr_cfg(lcsf_pkg::FMT_SINGLE, i[0]);
      fill(i[0] ? 32'h0000_0000 : 32'hFFFF_FFFF);
      run(64);
      chk_frame(i[0]);
      pop(lcsf_line_model_inst.up[0]);
      run(64);
      chk_frame(i[0]);
      pop(lcsf_line_model_inst.up[0]);
    end
    rx_ready = 1'b1;
    mon_byte = 8'($random(seed));
    mon_valid = 1'b1;
    run(64);
    mon_valid = 1'b0;
    chk(lcsf_line_model_inst.cap[0], {w[0][31:16], mon_byte, w[0][7:1], 1'b1});
    run(64);
    chk(lcsf_line_model_inst.cap[0], w[0]);
    chk(32'(mon_ready), 32'h1);
    rx_ready = 1'b0;
    for (i = 1; i < 4; i++) begin
      lcsf_line_model_inst.up[0] = 32'(i);
      run(64);
    end
    chk(32'(ovf), 32'h1);
    pop(32'h1);
    pop(32'h2);
    chk(32'(rx_valid), 32'h0);
    wr_cfg(lcsf_pkg::FMT_PINGPONG, 1'b0);
    chk(32'(ovf), 32'h0);
    rx_ready = 1'b1;
    run(64);
    chk(32'(lcsf_line_model_inst.dirc), 32'd32);
    chk_frame(1'b1);
    clk_en = 1'b0;
    repeat (3) @(negedge clk);
    clk_en = 1'b1;
    finish_test();
  end
endmodule // lcsf_frame_tb_top

bind lcsf_frame lcsf_frame_asserts lcsf_frame_asserts_inst (.*);
